// file: common/dac_pkg.sv
// Constants for the accumulator arithmetic datapath
package dac_pkg;
   localparam int ADDR_W  = 8;
   localparam int DATA_W  = 32;
   localparam int ACC_W   = 24;
   localparam int GUARD_W = 8;
   localparam int NUM_REG = 6;
   localparam int SEL_W   = 3;
   localparam int OP_W    = 4;
   localparam int FLAG_W  = 7;
   // Register offsets (byte addresses)
   localparam logic [7:0] OFS_CMD   = 8'h00;
   localparam logic [7:0] OFS_FLAGS = 8'h04;
   localparam logic [7:0] OFS_ACC0  = 8'h10;
   localparam logic [7:0] OFS_LAST  = 8'h24;
   // Command register fields
   localparam int CMD_OP_LSB  = 0;
   localparam int CMD_DST_LSB = 4;
   localparam int CMD_SRC_LSB = 8;
   // Operation codes
   localparam logic [3:0] OP_NOP  = 4'h0;
   localparam logic [3:0] OP_ABS  = 4'h1;
   localparam logic [3:0] OP_ABST = 4'h2;
   localparam logic [3:0] OP_ADD  = 4'h3;
   localparam logic [3:0] OP_SUB  = 4'h4;
   localparam logic [3:0] OP_CMP  = 4'h5;
   localparam logic [3:0] OP_NEG  = 4'h6;
   localparam logic [3:0] OP_NEGT = 4'h7;
   // Flag register bit positions
   localparam int FLG_C  = 0;
   localparam int FLG_Z  = 1;
   localparam int FLG_V  = 2;
   localparam int FLG_N  = 3;
   localparam int FLG_G0 = 4;
   localparam int FLG_G1 = 5;
   localparam int FLG_T  = 6;
   // Register slots 4 and 5 are the multiplier accumulator high parts
   localparam logic [2:0] MAC_BASE = 3'h4;
   localparam logic [23:0] ACC_RST = 24'h000000;
endpackage

// file: rtl/dac_alu.sv
// Accumulator datapath with flag update, reached over APB
//
// The APB register port and the register offsets were decided locally.
`timescale 1ns/1ns
// Operation
// - Guard flag changes only when first operand is a mac high part
// - Conditional ops run only while condition bit is 1, else no-op
// - Absolute value of selected 24-bit accumulator written back to it
// - Carry flag set on carry out of the computation, cleared otherwise
// - Zero flag set when the 24-bit result is zero, cleared otherwise
// - Overflow flag set on signed overflow, cleared otherwise
// - Sign flag is overflow XOR result MSB, true sign after overflow
// - First operand is source and destination, second only a source
module dac_alu #(
   parameter int ACC_W   = dac_pkg::ACC_W,
   parameter int GUARD_W = dac_pkg::GUARD_W
) (
   input  wire logic                       core_clk,
   input  wire logic                       srst,
   input  wire logic [dac_pkg::ADDR_W-1:0] paddr,
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [dac_pkg::DATA_W-1:0] pwdata,
   output logic      [dac_pkg::DATA_W-1:0] prdata,
   output logic                            pready,
   output logic                            pslverr,
   output logic                            adder_spill_bit,
   output logic                            all_clear_bit,
   output logic                            excess_bit,
   output logic                            polarity_bit,
   output logic      [1:0]                 mac_guard_ovf,
   output logic                            cond_pass_flag
);
   localparam int DW = dac_pkg::DATA_W;

   logic [ACC_W-1:0]      acc [dac_pkg::NUM_REG];
   logic [GUARD_W-1:0]    guard [2];
   logic [dac_pkg::OP_W-1:0]  cmd_op;
   logic [dac_pkg::SEL_W-1:0] cmd_dst;
   logic [dac_pkg::SEL_W-1:0] cmd_src;
   logic                  exec;

   // Sum of a, b and carry in, with carry out on top
   function automatic logic [ACC_W:0] add3(input logic [ACC_W-1:0] a,
                                           input logic [ACC_W-1:0] b,
                                           input logic cin);
      add3 = {1'b0, a} + {1'b0, b} + {{ACC_W{1'b0}}, cin};
   endfunction

   function automatic logic sel_ok(input logic [dac_pkg::SEL_W-1:0] s);
      sel_ok = (32'(s) < dac_pkg::NUM_REG);
   endfunction

   // APB decode
   wire xfer     = psel & penable & pready;
   wire wr_xfer  = xfer & pwrite;
   wire in_acc   = (paddr >= dac_pkg::OFS_ACC0) &&
                   (paddr <= dac_pkg::OFS_LAST) && (paddr[1:0] == 2'b00);
   wire [2:0] acc_idx = 3'((paddr - dac_pkg::OFS_ACC0) >> 2);
   wire hit_cmd  = (paddr == dac_pkg::OFS_CMD);
   wire hit_flg  = (paddr == dac_pkg::OFS_FLAGS);
   wire mapped   = hit_cmd | hit_flg | in_acc;
   wire [dac_pkg::FLAG_W-1:0] flag_vec = {cond_pass_flag, mac_guard_ovf,
      polarity_bit, excess_bit, all_clear_bit, adder_spill_bit};
   wire [DW-1:0] rd_val =
      hit_cmd ? DW'({cmd_src, 1'b0, cmd_dst, cmd_op}) :
      hit_flg ? DW'(flag_vec) :
      in_acc  ? DW'(acc[acc_idx]) : '0;

   // Operand selection: dst is source and destination, src only read
   wire dst_ok   = sel_ok(cmd_dst);
   wire [ACC_W-1:0] opa = dst_ok ? acc[cmd_dst] : '0;
   wire [ACC_W-1:0] opb = sel_ok(cmd_src) ? acc[cmd_src] : '0;
   wire is_cond  = (cmd_op == dac_pkg::OP_ABST) | (cmd_op == dac_pkg::OP_NEGT);
   wire is_abs   = (cmd_op == dac_pkg::OP_ABS) | (cmd_op == dac_pkg::OP_ABST);
   wire is_neg   = (cmd_op == dac_pkg::OP_NEG) | (cmd_op == dac_pkg::OP_NEGT);
   wire is_sub   = (cmd_op == dac_pkg::OP_SUB) | (cmd_op == dac_pkg::OP_CMP);
   wire is_add   = (cmd_op == dac_pkg::OP_ADD);
   wire known    = is_abs | is_neg | is_sub | is_add;
   wire cond_ok  = ~is_cond | cond_pass_flag;
   wire active   = exec & dst_ok & known & cond_ok;
   wire writes   = active & (cmd_op != dac_pkg::OP_CMP);
   wire dst_mac  = (cmd_dst >= dac_pkg::MAC_BASE);
   // Negation, and absolute value of a negative x, are 0 + ~x + 1
   wire flip     = is_neg | (is_abs & opa[ACC_W-1]);
   wire [ACC_W-1:0] in_a = (is_abs | is_neg) ? '0 : opa;
   wire [ACC_W-1:0] in_b = (is_abs | is_neg) ? (flip ? ~opa : opa) :
                           is_sub ? ~opb : opb;
   wire          cin   = flip | is_sub;
   wire [ACC_W:0] sum  = add3(in_a, in_b, cin);
   wire [ACC_W-1:0] res = sum[ACC_W-1:0];
   wire next_c = sum[ACC_W];
   wire next_z = (res == '0);
   wire next_v = (in_a[ACC_W-1] == in_b[ACC_W-1]) &&
                 (res[ACC_W-1] != in_a[ACC_W-1]);
   wire next_n = next_v ^ res[ACC_W-1];
   wire mac_sel = cmd_dst[0];

   // Bus slave: one wait state, answer registered
   always_ff @(posedge core_clk) begin
      if (srst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end else begin
         pready  <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & ~mapped;
         if (psel & penable & ~pready) begin
            prdata <= pwrite ? '0 : rd_val;
         end
      end
   end

   // Command capture; execution follows one cycle later
   always_ff @(posedge core_clk) begin
      if (srst) begin
         cmd_op  <= dac_pkg::OP_NOP;
         cmd_dst <= '0;
         cmd_src <= '0;
         exec    <= 1'b0;
      end else begin
         exec <= wr_xfer & hit_cmd;
         if (wr_xfer & hit_cmd) begin
            cmd_op  <= pwdata[dac_pkg::CMD_OP_LSB +: dac_pkg::OP_W];
            cmd_dst <= pwdata[dac_pkg::CMD_DST_LSB +: dac_pkg::SEL_W];
            cmd_src <= pwdata[dac_pkg::CMD_SRC_LSB +: dac_pkg::SEL_W];
         end
      end
   end

   // Register file: software writes first, datapath result last
   always_ff @(posedge core_clk) begin
      if (srst) begin
         for (int i = 0; i < dac_pkg::NUM_REG; i++) begin
            acc[i] <= dac_pkg::ACC_RST;
         end
         guard[0] <= '0;
         guard[1] <= '0;
      end else begin
         if (wr_xfer & in_acc) begin
            acc[acc_idx] <= pwdata[ACC_W-1:0];
         end
         if (writes) begin
            acc[cmd_dst] <= res;
            if (dst_mac) begin
               guard[mac_sel] <= {GUARD_W{next_n}};
            end
         end
      end
   end

   // Flags: hardware update wins over a software write
   always_ff @(posedge core_clk) begin
      if (srst) begin
         adder_spill_bit <= 1'b0;
         all_clear_bit   <= 1'b0;
         excess_bit      <= 1'b0;
         polarity_bit    <= 1'b0;
         mac_guard_ovf   <= 2'b00;
         cond_pass_flag  <= 1'b0;
      end else begin
         if (wr_xfer & hit_flg) begin
            adder_spill_bit <= pwdata[dac_pkg::FLG_C];
            all_clear_bit   <= pwdata[dac_pkg::FLG_Z];
            excess_bit      <= pwdata[dac_pkg::FLG_V];
            polarity_bit    <= pwdata[dac_pkg::FLG_N];
            mac_guard_ovf   <= pwdata[dac_pkg::FLG_G1:dac_pkg::FLG_G0];
            cond_pass_flag  <= pwdata[dac_pkg::FLG_T];
         end
         if (active & ~dst_mac) begin
            adder_spill_bit <= next_c;
            all_clear_bit   <= next_z;
            excess_bit      <= next_v;
            polarity_bit    <= next_n;
         end
         if (active & dst_mac) begin
            mac_guard_ovf[mac_sel] <= next_v;
         end
      end
   end

   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);

   sequence s_acc_op;
      active & ~dst_mac;
   endsequence
   sequence s_cond_skip;
      exec & is_cond & ~cond_pass_flag;
   endsequence

   a_cond_no_op: assert property (s_cond_skip |=>
      $stable(acc[0]) && $stable(acc[4]) && $stable(excess_bit) &&
      $stable(adder_spill_bit) && $stable(mac_guard_ovf) &&
      $stable(all_clear_bit) && $stable(polarity_bit))
      else $error("conditional op changed state with condition clear");
   a_abs_result: assert property (exec & is_abs & cond_ok &
      (cmd_dst == 3'h0) |=> acc[0] == ($past(acc[0][ACC_W-1]) ?
      ACC_W'(-$past(acc[0])) : $past(acc[0])))
      else $error("absolute value not written back");
   a_carry_flag: assert property (s_acc_op |=>
      adder_spill_bit == $past(sum[ACC_W]))
      else $error("carry flag wrong");
   a_zero_flag: assert property (s_acc_op ##1
      (cmd_op != dac_pkg::OP_CMP) |->
      all_clear_bit == (acc[$past(cmd_dst)] == '0))
      else $error("zero flag does not match result");
   a_ovf_flag: assert property (active & ~dst_mac & is_add &
      (opa[ACC_W-1] == opb[ACC_W-1]) |=> excess_bit ==
      ($past(res[ACC_W-1]) != $past(opa[ACC_W-1])))
      else $error("overflow flag wrong on add");
   a_sign_flag: assert property (s_acc_op |=>
      polarity_bit == (excess_bit ^ $past(res[ACC_W-1])))
      else $error("sign flag is not overflow xor msb");
   a_guard_hold: assert property (active & ~dst_mac &
      ~(wr_xfer & hit_flg) |=> $stable(mac_guard_ovf))
      else $error("guard flag changed for non-mac operand");
   a_src_kept: assert property (active & is_add &
      (cmd_src != cmd_dst) & (cmd_src == 3'h1) |=> $stable(acc[1]))
      else $error("second operand was modified");
   a_mac_flags: assert property (active & dst_mac |=>
      $stable(adder_spill_bit) && $stable(all_clear_bit))
      else $error("unlisted flags changed on mac operation");
endmodule

// file: tb/dac_host.sv
// Host-side APB master that issues datapath commands
`timescale 1ns/1ns
module dac_host (
   input  wire logic        core_clk,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr,
   output logic      [7:0]  paddr,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic      [31:0] pwdata
);
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
   end
   task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] rd, output logic er);
      @(posedge core_clk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // Released bus shows garbage, not the last value
      paddr   <= ~a;
      pwdata  <= ~d;
   endtask
endmodule

// file: tb/tb.sv
// Bench comparing the datapath with a reference model
`timescale 1ns/1ns
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_total++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
   logic        core_clk, srst, psel, penable, pwrite, pready, pslverr;
   logic        c_o, z_o, v_o, n_o, t_o, er;
   logic [1:0]  g_o;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd, k;
   logic [23:0] acc [6];
   logic [23:0] tbl [4] = '{24'h800000, 24'h7FFFFF, 24'h000001, 24'hFFFFFF};
   logic [6:0]  flg;
   int          err_total, checks, seed;
   dac_host u_dac_host (.core_clk(core_clk), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata));
   dac_alu u_dac_alu (.core_clk(core_clk), .srst(srst), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .adder_spill_bit(c_o), .all_clear_bit(z_o), .excess_bit(v_o),
      .polarity_bit(n_o), .mac_guard_ovf(g_o), .cond_pass_flag(t_o));
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      u_dac_host.xfer(1'b1, a, d, rd, er);
   endtask
   task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
      u_dac_host.xfer(1'b0, a, 32'h0, rd, er);
      `CHK(rd, e)
   endtask
   task automatic run(input logic [3:0] op, input int d, input int s);
      logic [23:0] x, y;
      logic [24:0] r;
      logic        sb, v, go;
      go = d < 6 && op inside {[1:7]} && (flg[6] ||
         (op != dac_pkg::OP_ABST && op != dac_pkg::OP_NEGT));
      x = acc[d % 6];
      y = acc[s];
      sb = 1'b1;
      case (op)
         dac_pkg::OP_ADD: sb = 1'b0;
         dac_pkg::OP_NEG, dac_pkg::OP_NEGT: begin
            y = x;
            x = '0;
         end
         dac_pkg::OP_ABS, dac_pkg::OP_ABST: begin
            // Non-negative input passes through with no carry
            sb = x[23];
            y = x[23] ? x : '0;
            x = x[23] ? '0 : x;
         end
         default: ;
      endcase
      y = sb ? ~y : y;
      r = {1'b0, x} + {1'b0, y} + 25'(sb);
      v = x[23] == y[23] && r[23] != x[23];
      wr(dac_pkg::OFS_CMD, {21'h0, 3'(s), 1'b0, 3'(d), op});
      if (go && d > 3) flg[dac_pkg::FLG_G0 + d - 4] = v;
      else if (go) flg[3:0] = {v ^ r[23], v, r[23:0] == 0, r[24]};
      if (go && op != dac_pkg::OP_CMP) acc[d] = r[23:0];
      repeat (2) @(posedge core_clk);
      #1;
      `CHK(c_o, flg[dac_pkg::FLG_C])
      `CHK(z_o, flg[dac_pkg::FLG_Z])
      `CHK(v_o, flg[dac_pkg::FLG_V])
      `CHK(n_o, flg[dac_pkg::FLG_N])
      `CHK({t_o, g_o}, flg[6:4])
      if (d < 6) chk_rd(dac_pkg::OFS_ACC0 + 8'(4 * d),
         {8'h0, acc[d]});
      chk_rd(dac_pkg::OFS_ACC0 + 8'(4 * s), {8'h0, acc[s]});
   endtask
   task automatic print_verdict();
      $display("checks %0d err_total %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   initial begin
      #200000;
      err_total++;
      print_verdict();
   end
   initial begin
      seed = 60;
      flg = '0;
      acc = '{default: '0};
      srst = 1'b1;
      repeat (8) @(posedge core_clk);
      srst <= 1'b0;
      chk_rd(dac_pkg::OFS_FLAGS, 32'h0);
      chk_rd(dac_pkg::OFS_ACC0, 32'h0);
      chk_rd(8'h08, 32'h0);
      `CHK(er, 1'b1)
      for (int i = 0; i < 400; i++) begin
         k = $random(seed);
         if (k[1:0] == 2'h0) begin
            flg[6] = k[4];
            wr(dac_pkg::OFS_FLAGS, {25'h0, flg});
         end else if (k[1:0] == 2'h1) begin
            acc[k[6:4] % 6] = k[10] ? k[31:8] : tbl[k[9:8]];
            wr(dac_pkg::OFS_ACC0 + 8'(4 * (k[6:4] % 6)),
               {k[7:0], acc[k[6:4] % 6]});
         end else begin
            run(k[7:4] == 4'hF ? 4'hF : {1'b0, k[6:4]}, k[10:8], k[13:11] % 6);
         end
      end
      print_verdict();
   end
endmodule
